// >>> verilog/timer8_pkg.sv
// timer8_pkg: register offsets, field positions, reset values and mode codes
// assumes a 32-bit AXI4-Lite slave with one aligned word per register
package timer8_pkg;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CONTROL_REG_A = 8'h00;
  localparam logic [7:0] OFS_CONTROL_REG_B = 8'h04;
  localparam logic [7:0] OFS_COUNT_VALUE   = 8'h08;
  localparam logic [7:0] OFS_COMPARE_A     = 8'h0C;
  localparam logic [7:0] OFS_COMPARE_B     = 8'h10;
  localparam logic [7:0] OFS_INT_MASK      = 8'h14;
  localparam logic [7:0] OFS_INT_FLAGS     = 8'h18;
  localparam logic [7:0] OFS_PORT_CTRL     = 8'h1C;
  localparam logic [7:0] OFS_PIN_STATE     = 8'h20;

  // ****************************************************************
  // field positions
  // ****************************************************************
  // control_reg_a: [7:6] output_mode a, [5:4] output_mode b, [1:0] wave_mode_bit1:0
  localparam int POS_OM_A   = 6;
  localparam int POS_OM_B   = 4;
  localparam int POS_WM_LO  = 0;
  // control_reg_b: [7] force a, [6] force b, [3] wave_mode_bit2, [2:0] clock_select
  localparam int POS_FORCE_A = 7;
  localparam int POS_FORCE_B = 6;
  localparam int POS_WM_HI   = 3;
  localparam int POS_CS      = 0;
  // flags and mask: [2] channel b, [1] channel a, [0] overflow
  localparam int POS_FLAG_OV = 0;
  localparam int POS_FLAG_A  = 1;
  localparam int POS_FLAG_B  = 2;
  // port control: [1:0] port value, [3:2] port direction
  localparam int POS_PORT_VAL = 0;
  localparam int POS_PORT_DIR = 2;

  // ****************************************************************
  // values
  // ****************************************************************
  localparam logic [7:0] VAL_BOTTOM = 8'h00;
  localparam logic [7:0] VAL_MAX    = 8'hFF;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // wave_mode codes
  localparam logic [2:0] WM_NORMAL       = 3'h0;
  localparam logic [2:0] WM_PC_MAX       = 3'h1;
  localparam logic [2:0] WM_CLR_ON_MATCH = 3'h2;
  localparam logic [2:0] WM_FAST_MAX     = 3'h3;
  localparam logic [2:0] WM_PC_CMPA      = 3'h5;
  localparam logic [2:0] WM_FAST_CMPA    = 3'h7;

  // output_mode codes
  localparam logic [1:0] OM_OFF    = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR  = 2'h2;
  localparam logic [1:0] OM_SET    = 2'h3;

endpackage

// >>> verilog/timer8_counter_compare_output.sv
// timer8_counter_compare_output: 8-bit up/down counter, two compare units,
// waveform outputs and an AXI4-Lite register slave
// assumes TIMER_TICK is a one-cycle enable on CLK from an external prescaler,
// and INT_ACK_* are one-cycle pulses from the interrupt controller
//
// Overview of operation
// RULE1 - 8-bit counter clears, increments or decrements per tick
// RULE2 - clock select zero stops the counter
// RULE3 - CPU counter write beats clear and count
// RULE4 - three-bit wave mode split across two controls
// RULE5 - overflow flag set per mode, raises interrupt
// RULE6 - comparator flags equality of counter and compare
// RULE7 - match flag set one tick later, interrupts
// RULE8 - match flag clears when interrupt executes
// RULE9 - writing one clears a flag, zero keeps
// RULE10 - PWM modes double buffer compare, update TOP/BOTTOM
// RULE11 - CPU reaches buffer when buffered, else active
// RULE12 - force strobe acts as match, no flag
// RULE13 - counter write blocks matches next tick
// RULE14 - output state kept across wave mode changes
// RULE15 - output mode unbuffered, acts at next match
// RULE16 - output state reset to zero
// RULE17 - nonzero output mode overrides port value
// RULE18 - output mode zero leaves state unchanged
// RULE19 - non-PWM: off, toggle, clear, set on match
// RULE20 - fast PWM: clear/set at match and BOTTOM
// RULE21 - phase-correct: action depends on count direction
// RULE22 - compare at TOP ignored, acts at BOTTOM/TOP
// RULE23 - BOTTOM is 0x00, MAX is 0xFF
// RULE24 - TOP is 0xFF or compare value A
// RULE25 - two identical channels share counter and mode; PWM toggle acts on channel a only
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/100ps
module timer8_counter_compare_output
  import timer8_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // timer tick and interrupt acknowledges
  input  wire logic        TIMER_TICK,
  input  wire logic        INT_ACK_OV,
  input  wire logic        INT_ACK_A,
  input  wire logic        INT_ACK_B,
  // axi4-lite write address
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  // axi4-lite write data
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // axi4-lite read
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // interrupt requests to the cpu core
  output logic             IRQ_OV,
  output logic             IRQ_A,
  output logic             IRQ_B,
  // wave pins
  output logic             WAVE_OUT_A,
  output logic             WAVE_OUT_A_OE,
  output logic             WAVE_OUT_B,
  output logic             WAVE_OUT_B_OE
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0] count_value;
    logic       count_down;
    logic [1:0] om_a;
    logic [1:0] om_b;
    logic [2:0] wave_mode;
    logic [2:0] clock_select;
    logic [7:0] cmp_act_a;
    logic [7:0] cmp_act_b;
    logic [7:0] cmp_buf_a;
    logic [7:0] cmp_buf_b;
    logic [2:0] int_mask;
    logic       overflow_flag;
    logic       match_flag_a;
    logic       match_flag_b;
    logic       block_q;
    logic [1:0] wave_out;
    logic [1:0] port_val;
    logic [1:0] port_dir;
    logic       aw_got;
    logic       w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t st_q;
  state_t st_d;

  // ****************************************************************
  // combinational helpers
  // ****************************************************************
  logic       tick;
  logic       is_fast;
  logic       is_pc;
  logic       is_pwm;
  logic [7:0] top_val;
  logic       at_top;
  logic       at_bottom;
  logic       at_max;
  logic [1:0] match;
  logic [7:0] cmp_act [2];
  logic [1:0] om [2];
  logic [1:0] force_bit;
  logic       wr_fire;
  logic       rd_fire;
  logic       wr_cnt;
  logic [7:0] wbyte;

  always_comb begin
    tick      = TIMER_TICK && (st_q.clock_select != 3'h0); // [RULE2]
    is_fast   = (st_q.wave_mode == WM_FAST_MAX) || (st_q.wave_mode == WM_FAST_CMPA);
    is_pc     = (st_q.wave_mode == WM_PC_MAX) || (st_q.wave_mode == WM_PC_CMPA);
    is_pwm    = is_fast || is_pc;
    // top from compare a in clear-on-match and the high-bit pwm modes
    top_val   = (st_q.wave_mode == WM_CLR_ON_MATCH || st_q.wave_mode[2]) ?
                st_q.cmp_act_a : VAL_MAX; // [RULE24]
    at_top    = (st_q.count_value == top_val);
    at_bottom = (st_q.count_value == VAL_BOTTOM); // [RULE23]
    at_max    = (st_q.count_value == VAL_MAX); // [RULE23]
    cmp_act[0] = st_q.cmp_act_a;
    cmp_act[1] = st_q.cmp_act_b;
    om[0]     = st_q.om_a;
    om[1]     = st_q.om_b;
    wr_fire   = st_q.aw_got && st_q.w_got && !st_q.bvalid;
    rd_fire   = S_AXI_ARVALID && !st_q.rvalid;
    wbyte     = st_q.w_data[7:0];
    wr_cnt    = wr_fire && st_q.w_strb[0] && (st_q.aw_addr == OFS_COUNT_VALUE);
    force_bit[0] = wr_fire && st_q.w_strb[0] && (st_q.aw_addr == OFS_CONTROL_REG_B) &&
                   wbyte[POS_FORCE_A] && !is_pwm; // [RULE12]
    force_bit[1] = wr_fire && st_q.w_strb[0] && (st_q.aw_addr == OFS_CONTROL_REG_B) &&
                   wbyte[POS_FORCE_B] && !is_pwm; // [RULE12]
  end

  // per-channel comparator, identical for both units
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_cmp
      assign match[ch] = (st_q.count_value == cmp_act[ch]); // [RULE6] [RULE25]
    end
  endgenerate

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic       hit;
    logic       cur;
    logic       nxt;
    logic [1:0] mode;
    logic       cmp_is_top;
    logic       ov_set;
    logic [1:0] seen;
    hit  = 1'b0;
    cur  = 1'b0;
    nxt  = 1'b0;
    mode = OM_OFF;
    cmp_is_top = 1'b0;
    ov_set = 1'b0;
    seen = 2'b00;
    st_d = st_q;

    // counter sequence per wave mode
    if (tick) begin
      st_d.block_q = 1'b0;
      if (is_pc) begin
        if (!st_q.count_down && at_top) begin
          st_d.count_down  = 1'b1;
          st_d.count_value = st_q.count_value - 8'h01; // [RULE1]
        end else if (st_q.count_down && at_bottom) begin
          st_d.count_down  = 1'b0;
          st_d.count_value = st_q.count_value + 8'h01;
        end else if (st_q.count_down) begin
          st_d.count_value = st_q.count_value - 8'h01;
        end else begin
          st_d.count_value = st_q.count_value + 8'h01;
        end
      end else begin
        st_d.count_down = 1'b0;
        if ((is_fast || st_q.wave_mode == WM_CLR_ON_MATCH) && at_top) begin
          st_d.count_value = VAL_BOTTOM; // [RULE1]
        end else begin
          st_d.count_value = st_q.count_value + 8'h01;
        end
      end

      // overflow point per mode [RULE5]
      if (is_pc ? (st_q.count_down && at_bottom) :
          (st_q.wave_mode == WM_FAST_CMPA ? at_top : at_max)) begin
        st_d.overflow_flag = 1'b1;
        ov_set             = 1'b1;
      end

      // buffered compare load: bottom in fast pwm, top in phase correct [RULE10]
      if ((is_fast && at_top) || (is_pc && at_top && !st_q.count_down)) begin
        st_d.cmp_act_a = st_q.cmp_buf_a;
        st_d.cmp_act_b = st_q.cmp_buf_b;
      end

      // match standing at this tick, blocked after a counter write [RULE13]
      seen = st_q.block_q ? 2'b00 : match;
    end

    // flag set one tick after match detection [RULE7]
    if (seen[0]) st_d.match_flag_a = 1'b1;
    if (seen[1]) st_d.match_flag_b = 1'b1;

    // waveform generator per channel
    for (int c = 0; c < 2; c++) begin
      mode = om[c]; // [RULE15]
      cur  = st_q.wave_out[c];
      nxt  = cur; // [RULE14] [RULE18]
      cmp_is_top = (cmp_act[c] == top_val) && mode[1];
      hit  = tick && match[c] && !st_q.block_q;
      if (!is_pwm) begin
        if (hit || force_bit[c]) begin
          unique case (mode) // [RULE19]
            OM_OFF:    nxt = cur;
            OM_TOGGLE: nxt = !cur;
            OM_CLEAR:  nxt = 1'b0;
            OM_SET:    nxt = 1'b1;
          endcase
        end
      end else if (mode == OM_TOGGLE) begin
        // toggle only on channel a with the high mode bit [RULE20]
        if (c == 0 && st_q.wave_mode[2] && hit) nxt = !cur;
      end else if (mode[1]) begin
        if (is_fast) begin
          if (hit && !cmp_is_top) nxt = mode[0]; // [RULE20]
          if (tick && at_top) nxt = !mode[0]; // [RULE22]
        end else begin
          if (hit && !cmp_is_top) nxt = st_q.count_down ^ mode[0]; // [RULE21]
          if (tick && at_top && cmp_is_top) nxt = mode[0] ? 1'b0 : 1'b1; // [RULE22]
        end
      end
      st_d.wave_out[c] = nxt;
    end

    // acknowledge clears, then set wins over clear [RULE8]
    if (INT_ACK_OV && !ov_set) st_d.overflow_flag = 1'b0;
    if (INT_ACK_A && !seen[0]) st_d.match_flag_a = 1'b0;
    if (INT_ACK_B && !seen[1]) st_d.match_flag_b = 1'b0;

    // axi write channel capture
    if (S_AXI_AWVALID && !st_q.aw_got) begin
      st_d.aw_got  = 1'b1;
      st_d.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !st_q.w_got) begin
      st_d.w_got  = 1'b1;
      st_d.w_data = S_AXI_WDATA;
      st_d.w_strb = S_AXI_WSTRB;
    end

    // register write
    if (wr_fire) begin
      st_d.aw_got = 1'b0;
      st_d.w_got  = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp  = AXI_OKAY;
      if (st_q.w_strb[0]) begin
        unique case (st_q.aw_addr)
          OFS_CONTROL_REG_A: begin
            st_d.om_a = wbyte[POS_OM_A +: 2];
            st_d.om_b = wbyte[POS_OM_B +: 2];
            st_d.wave_mode[1:0] = wbyte[POS_WM_LO +: 2]; // [RULE4]
          end
          OFS_CONTROL_REG_B: begin
            st_d.wave_mode[2]  = wbyte[POS_WM_HI]; // [RULE4]
            st_d.clock_select  = wbyte[POS_CS +: 3];
          end
          OFS_COUNT_VALUE: begin
            st_d.count_value = wbyte; // [RULE3]
            st_d.block_q     = 1'b1; // [RULE13]
          end
          OFS_COMPARE_A: begin
            if (is_pwm) st_d.cmp_buf_a = wbyte; // [RULE11]
            else begin
              st_d.cmp_act_a = wbyte;
              st_d.cmp_buf_a = wbyte;
            end
          end
          OFS_COMPARE_B: begin
            if (is_pwm) st_d.cmp_buf_b = wbyte; // [RULE11]
            else begin
              st_d.cmp_act_b = wbyte;
              st_d.cmp_buf_b = wbyte;
            end
          end
          OFS_INT_MASK: st_d.int_mask = wbyte[2:0];
          OFS_INT_FLAGS: begin
            // one clears, set in the same cycle wins [RULE9]
            if (wbyte[POS_FLAG_OV] && !ov_set) st_d.overflow_flag = 1'b0;
            if (wbyte[POS_FLAG_A] && !seen[0]) st_d.match_flag_a = 1'b0;
            if (wbyte[POS_FLAG_B] && !seen[1]) st_d.match_flag_b = 1'b0;
          end
          OFS_PORT_CTRL: begin
            st_d.port_val = wbyte[POS_PORT_VAL +: 2];
            st_d.port_dir = wbyte[POS_PORT_DIR +: 2];
          end
          OFS_PIN_STATE: st_d.bresp = AXI_OKAY;
          default:       st_d.bresp = AXI_SLVERR;
        endcase
      end
    end
    if (st_q.bvalid && S_AXI_BREADY) st_d.bvalid = 1'b0;

    // register read
    if (rd_fire) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = AXI_OKAY;
      st_d.rdata  = 32'h0000_0000;
      unique case (S_AXI_ARADDR)
        OFS_CONTROL_REG_A: st_d.rdata[7:0] = {st_q.om_a, st_q.om_b, 2'b00,
                                              st_q.wave_mode[1:0]};
        OFS_CONTROL_REG_B: st_d.rdata[7:0] = {4'h0, st_q.wave_mode[2], st_q.clock_select};
        OFS_COUNT_VALUE:   st_d.rdata[7:0] = st_q.count_value;
        OFS_COMPARE_A:     st_d.rdata[7:0] = is_pwm ? st_q.cmp_buf_a : st_q.cmp_act_a;
        OFS_COMPARE_B:     st_d.rdata[7:0] = is_pwm ? st_q.cmp_buf_b : st_q.cmp_act_b;
        OFS_INT_MASK:      st_d.rdata[2:0] = st_q.int_mask;
        OFS_INT_FLAGS:     st_d.rdata[2:0] = {st_q.match_flag_b, st_q.match_flag_a,
                                              st_q.overflow_flag};
        OFS_PORT_CTRL:     st_d.rdata[3:0] = {st_q.port_dir, st_q.port_val};
        OFS_PIN_STATE:     st_d.rdata[1:0] = st_q.wave_out;
        default:           st_d.rresp = AXI_SLVERR;
      endcase
    end
    if (st_q.rvalid && S_AXI_RREADY) st_d.rvalid = 1'b0;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_q <= '0; // [RULE16]
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign S_AXI_AWREADY = !st_q.aw_got;
  assign S_AXI_WREADY  = !st_q.w_got;
  assign S_AXI_BVALID  = st_q.bvalid;
  assign S_AXI_BRESP   = st_q.bresp;
  assign S_AXI_ARREADY = !st_q.rvalid;
  assign S_AXI_RVALID  = st_q.rvalid;
  assign S_AXI_RDATA   = st_q.rdata;
  assign S_AXI_RRESP   = st_q.rresp;

  // interrupt requests gated by mask [RULE5] [RULE7]
  assign IRQ_OV = st_q.overflow_flag && st_q.int_mask[POS_FLAG_OV];
  assign IRQ_A  = st_q.match_flag_a && st_q.int_mask[POS_FLAG_A];
  assign IRQ_B  = st_q.match_flag_b && st_q.int_mask[POS_FLAG_B];

  // pin override when output mode nonzero, direction from port [RULE17]
  assign WAVE_OUT_A    = (st_q.om_a != OM_OFF) ? st_q.wave_out[0] : st_q.port_val[0];
  assign WAVE_OUT_A_OE = st_q.port_dir[0];
  assign WAVE_OUT_B    = (st_q.om_b != OM_OFF) ? st_q.wave_out[1] : st_q.port_val[1];
  assign WAVE_OUT_B_OE = st_q.port_dir[1];

endmodule

// >>> verif/timer8_counter_compare_output_asserts.sv
// port checker for the timer: bus answers, flag clearing, output stability
// assumes it is bound to timer8_counter_compare_output and sees its ports only
`timescale 1ns/100ps
module timer8_cco_asserts (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST,
  // tick and acknowledges
  input wire logic        TIMER_TICK,
  input wire logic        INT_ACK_A,
  input wire logic        INT_ACK_B,
  // bus handshakes
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  // interrupts and pins
  input wire logic        IRQ_OV,
  input wire logic        IRQ_A,
  input wire logic        IRQ_B,
  input wire logic        WAVE_OUT_A,
  input wire logic        WAVE_OUT_A_OE,
  input wire logic        WAVE_OUT_B,
  input wire logic        WAVE_OUT_B_OE
);
  // ****************************************************************
  // quiet counter: edges since the last tick or write beat
  // ****************************************************************
  logic [1:0] quiet_q;
  logic [1:0] quiet_d;

  // saturates at three, restarts on any cause of a pin change or a request rise
  always_comb begin
    quiet_d = quiet_q;
    if (TIMER_TICK || (S_AXI_AWVALID && S_AXI_AWREADY) || (S_AXI_WVALID && S_AXI_WREADY)) begin
      quiet_d = 2'h0;
    end else if (quiet_q != 2'h3) begin
      quiet_d = quiet_q + 2'h1;
    end
  end

  // register the counter
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      quiet_q <= 2'h0;
    end else begin
      quiet_q <= quiet_d;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // steps of the bus transfers and a tick-free window
  sequence s_wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_rd_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  sequence s_calm;
    !TIMER_TICK && !$past(TIMER_TICK);
  endsequence

  property p_reset_quiet;
    $fell(RST) |-> !(IRQ_OV || IRQ_A || IRQ_B || WAVE_OUT_A || WAVE_OUT_B || WAVE_OUT_A_OE
      || WAVE_OUT_B_OE);
  endproperty
  property p_wr_answer;
    s_wr_taken |-> ##[1:2] S_AXI_BVALID;
  endproperty
  property p_rd_answer;
    s_rd_taken |=> S_AXI_RVALID;
  endproperty
  property p_b_single;
    S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID;
  endproperty
  property p_ar_refused;
    S_AXI_RVALID |-> !S_AXI_ARREADY;
  endproperty
  property p_ack_a;
    (INT_ACK_A ##0 s_calm) |=> !IRQ_A;
  endproperty
  property p_ack_b;
    (INT_ACK_B ##0 s_calm) |=> !IRQ_B;
  endproperty
  property p_irq_cause;
    ($rose(IRQ_A) || $rose(IRQ_B) || $rose(IRQ_OV)) |-> quiet_q != 2'h3;
  endproperty
  property p_wave_still;
    quiet_q == 2'h3 |-> $stable(WAVE_OUT_A) && $stable(WAVE_OUT_B) && $stable(WAVE_OUT_A_OE)
      && $stable(WAVE_OUT_B_OE);
  endproperty

  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not idle");
  a_wr_answer: assert property (p_wr_answer) else $error("write response late");
  a_rd_answer: assert property (p_rd_answer) else $error("read data late");
  a_b_single: assert property (p_b_single) else $error("write response repeated");
  a_ar_refused: assert property (p_ar_refused) else $error("read taken while answer pending");
  a_ack_a: assert property (p_ack_a) else $error("ack left channel a request");
  a_ack_b: assert property (p_ack_b) else $error("ack left channel b request");
  a_irq_cause: assert property (p_irq_cause) else $error("request rose without cause");
  a_wave_still: assert property (p_wave_still) else $error("pin moved without cause");
endmodule

bind timer8_counter_compare_output timer8_cco_asserts i_chk (
  .CLK(CLK), .RST(RST), .TIMER_TICK(TIMER_TICK), .INT_ACK_A(INT_ACK_A), .INT_ACK_B(INT_ACK_B),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .IRQ_OV(IRQ_OV), .IRQ_A(IRQ_A), .IRQ_B(IRQ_B), .WAVE_OUT_A(WAVE_OUT_A),
  .WAVE_OUT_A_OE(WAVE_OUT_A_OE), .WAVE_OUT_B(WAVE_OUT_B), .WAVE_OUT_B_OE(WAVE_OUT_B_OE));

// >>> verif/timer8_counter_compare_output_tb.sv
// self-checking bench for the timer: register sequences over the bus
// assumes the package and the bound port checker are compiled first
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("Error %s exp %0h got %0h", nm, e, g); end end
module timer8_counter_compare_output_tb
  import timer8_pkg::*;
  ;
  logic        CLK, RST, tick, ack_ov, ack_a, ack_b, awvalid, wvalid, arvalid, bready, rready;
  logic        awready, wready, arready, bvalid, rvalid, irq_ov, irq_a, irq_b;
  logic        wa, wa_oe, wb, wb_oe;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rdata_s;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp_s;
  int          failures, n_checks, k, ch;
  logic [1:0]  om_tab [5] = '{OM_SET, OM_OFF, OM_TOGGLE, OM_CLEAR, OM_TOGGLE};
  logic        st_tab [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

  // design under test
  timer8_counter_compare_output i_dut (
    .CLK(CLK), .RST(RST), .TIMER_TICK(tick), .INT_ACK_OV(ack_ov), .INT_ACK_A(ack_a),
    .INT_ACK_B(ack_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .IRQ_OV(irq_ov), .IRQ_A(irq_a), .IRQ_B(irq_b),
    .WAVE_OUT_A(wa), .WAVE_OUT_A_OE(wa_oe), .WAVE_OUT_B(wb), .WAVE_OUT_B_OE(wb_oe));

  // 200 MHz clock
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  // ****************************************************************
  // bus tasks
  // ****************************************************************
  task automatic tally_and_finish();
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic guard(input int i);
    if (i >= 50) begin
      failures++;
      $display("Error bus answer exp 1 got 0");
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge CLK);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge CLK);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    guard(i);
    resp_s = bresp;
    @(posedge CLK);
  endtask

  task automatic rd(input logic [7:0] a);
    int i;
    @(posedge CLK);
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge CLK);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    guard(i);
    rdata_s = rdata;
    resp_s = rresp;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a);
    `CHK(nm, e, rdata_s)
  endtask

  // one-cycle ticks with a gap between them
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge CLK);
      tick <= 1'b1;
      @(posedge CLK);
      tick <= 1'b0;
    end
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {RST, bready, rready} = 3'h7;
    {tick, ack_ov, ack_a, ack_b, awvalid, wvalid, arvalid} = 7'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    failures = 0;
    n_checks = 0;
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    // reset values and an unmapped place
    for (k = 0; k <= 8; k++) rchk(8'(k * 4), 32'h0, "reset value");
    rd(8'h24);
    `CHK("read resp", AXI_SLVERR, resp_s)
    wr(8'h24, 32'hFF);
    `CHK("write resp", AXI_SLVERR, resp_s)
    // stopped counter, cpu writes, counting and overflow
    wr(OFS_COMPARE_A, 32'h10);
    wr(OFS_COMPARE_B, 32'h80);
    wr(OFS_COUNT_VALUE, 32'h05);
    ticks(5);
    rchk(OFS_COUNT_VALUE, 32'h05, "stopped");
    wr(OFS_CONTROL_REG_B, 32'h01);
    ticks(3);
    rchk(OFS_COUNT_VALUE, 32'h08, "count up");
    wr(OFS_COUNT_VALUE, 32'hFE);
    ticks(2);
    rchk(OFS_COUNT_VALUE, 32'h00, "wrap");
    rchk(OFS_INT_FLAGS, 32'h01, "overflow flag");
    wr(OFS_INT_MASK, 32'h01);
    `CHK("irq ov", 1'b1, irq_ov)
    wr(OFS_INT_FLAGS, 32'h06);
    rchk(OFS_INT_FLAGS, 32'h01, "write zero");
    wr(OFS_INT_FLAGS, 32'h01);
    rchk(OFS_INT_FLAGS, 32'h00, "write one");
    // match flag one tick late, cleared by the acknowledge
    wr(OFS_COUNT_VALUE, 32'h0E);
    ticks(2);
    rchk(OFS_INT_FLAGS, 32'h00, "flag early");
    ticks(1);
    rchk(OFS_INT_FLAGS, 32'h02, "flag a");
    wr(OFS_INT_MASK, 32'h07);
    `CHK("irq a", 1'b1, irq_a)
    `CHK("irq b", 1'b0, irq_b)
    {ack_ov, ack_a, ack_b} <= 3'h7;
    @(posedge CLK);
    {ack_ov, ack_a, ack_b} <= 3'h0;
    rchk(OFS_INT_FLAGS, 32'h00, "ack clears");
    // counter write equal to compare blocks the next match
    wr(OFS_COUNT_VALUE, 32'h10);
    ticks(2);
    rchk(OFS_INT_FLAGS, 32'h00, "blocked");
    wr(OFS_CONTROL_REG_B, 32'h00);
    wr(OFS_PORT_CTRL, 32'h0C);
    `CHK("oe", 2'h3, {wb_oe, wa_oe})
    // output modes through the force strobe, both channels
    for (ch = 0; ch < 2; ch++) begin
      for (k = 0; k < 5; k++) begin
        wr(OFS_CONTROL_REG_A, 32'(om_tab[k]) << (ch ? POS_OM_B : POS_OM_A));
        wr(OFS_CONTROL_REG_B, 32'h1 << (ch ? POS_FORCE_B : POS_FORCE_A));
        rd(OFS_PIN_STATE);
        `CHK("state", st_tab[k], rdata_s[ch])
        `CHK("pin", (om_tab[k] != OM_OFF) && st_tab[k], ch ? wb : wa)
      end
    end
    rchk(OFS_INT_FLAGS, 32'h00, "force flags");
    rchk(OFS_COUNT_VALUE, 32'h12, "force count");
    // fast pwm: buffered compare, clear on match, set at bottom
    wr(OFS_COMPARE_A, 32'h03);
    rchk(OFS_COMPARE_A, 32'h03, "direct");
    wr(OFS_CONTROL_REG_A, 32'h83);
    rchk(OFS_PIN_STATE, 32'h03, "mode kept");
    wr(OFS_COMPARE_A, 32'h05);
    rchk(OFS_COMPARE_A, 32'h05, "buffer");
    wr(OFS_COUNT_VALUE, 32'h02);
    wr(OFS_CONTROL_REG_B, 32'h01);
    ticks(2);
    rchk(OFS_PIN_STATE, 32'h02, "old compare");
    ticks(253);
    rchk(OFS_PIN_STATE, 32'h03, "set at bottom");
    ticks(3);
    rchk(OFS_PIN_STATE, 32'h03, "new compare wait");
    ticks(2);
    rchk(OFS_PIN_STATE, 32'h02, "new compare");
    `CHK("pin a", 1'b0, wa)
    rchk(OFS_COUNT_VALUE, 32'h06, "count");
    // phase correct: a match while counting down sets the output
    wr(OFS_CONTROL_REG_A, 32'h81);
    wr(OFS_COMPARE_A, 32'hFD);
    wr(OFS_COUNT_VALUE, 32'hFC);
    ticks(6);
    rchk(OFS_PIN_STATE, 32'h03, "down match");
    tally_and_finish();
  end
endmodule
